// ==== hdl/tcc_pkg.sv ====
/*
  Package for the 16-bit timer counter and input capture block: register
  offsets, field positions, reset values, counter top values and tick sources.
  Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
*/
package tcc_pkg;

  localparam logic [7:0] TCC_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] TCC_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] TCC_OFS_CNT_LO = 8'h08;
  localparam logic [7:0] TCC_OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] TCC_OFS_CAP_LO = 8'h10;
  localparam logic [7:0] TCC_OFS_CAP_HI = 8'h14;
  localparam logic [7:0] TCC_OFS_FLAGS = 8'h18;
  localparam logic [7:0] TCC_OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] TCC_OFS_CMP_CS = 8'h20;
  localparam logic [7:0] TCC_OFS_STATUS = 8'h24;

  localparam int TCC_A_WGM_LO = 0;
  localparam int TCC_B_CS = 0;
  localparam int TCC_B_WGM_HI = 3;
  localparam int TCC_B_EDGE = 6;
  localparam int TCC_B_FILT = 7;
  localparam int TCC_FLG_OVF = 0;
  localparam int TCC_FLG_CAP = 5;
  localparam int TCC_CMP_SEL = 2;
  localparam int TCC_ST_TOP = 0;
  localparam int TCC_ST_BOT = 1;
  localparam int TCC_ST_RUN = 2;

  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  localparam logic [15:0] TCC_MAX = 16'hFFFF;
  localparam logic [15:0] TCC_BOTTOM = 16'h0000;
  localparam logic [15:0] TCC_TOP_8 = 16'h00FF;
  localparam logic [15:0] TCC_TOP_9 = 16'h01FF;
  localparam logic [15:0] TCC_TOP_10 = 16'h03FF;
  localparam int TCC_FILT_LEN = 4;

  localparam logic [1:0] TCC_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCC_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TCC_CS_STOP = 3'h0,
    TCC_CS_DIV1 = 3'h1,
    TCC_CS_DIV8 = 3'h2,
    TCC_CS_DIV64 = 3'h3,
    TCC_CS_DIV256 = 3'h4,
    TCC_CS_DIV1024 = 3'h5,
    TCC_CS_EXT_FALL = 3'h6,
    TCC_CS_EXT_RISE = 3'h7
  } tcc_cs_t;

  typedef struct packed {
    logic top;
    logic bottom;
    logic overflow;
    logic capture;
  } tcc_event_t;

endpackage

// ==== hdl/tcc_timer.sv ====
/*
  Counter and input-capture part of a 16-bit timer, with an AXI4-Lite slave.
  Assumes one clock; the external count pin, capture pin and comparator
  output are asynchronous and are synchronised here.
*/
// Overview of operation
// - Counter seen as two bytes, upper via latch
// - Low read latches upper; low write loads it
// - Three-bit source select; zero stops counter
// - Each tick clears, increments or decrements counter
// - Counter accessible whether or not tick runs
// - Software write beats clear or count
// - Four-bit mode field split over two controls
// - Overflow flag set per mode, can interrupt
// - Top and bottom indications from counter
// - Selected edge copies counter to capture register
// - Capture flag set in same copy cycle
// - Capture flag interrupts; cleared by ack or one
// - Capture low read first loads latch
// - Capture register writable only in top modes
// - Trigger from pin or comparator by select
// - Source switch may capture; software clears flag
// - No captures in capture-top modes
// - Filter output changes after four agreeing samples
// - Filter adds four system cycles delay
// - Filter enable bit, runs on system clock
// - Maximum is all ones, bottom is zero
module tcc_timer
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and neighbouring logic.
  input wire logic external_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  // Interrupt requests and indications.
  output logic ovf_irq,
  output logic cap_irq,
  output logic top_ind,
  output logic bottom_ind
);

  function automatic logic [2:0] sync3(input logic [2:0] s, input logic d);
    sync3 = {s[1:0], d};
  endfunction

  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [7:0] comparator_ctrl_status;
  logic [15:0] timer_count;
  logic [15:0] capture_value;
  logic [7:0] high_latch;
  logic overflow_flag;
  logic capture_flag;
  logic capture_irq_enable;
  logic overflow_irq_enable;
  logic count_down;

  // Write path: address and data may arrive in either order.
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_b0 = w_strb[0];
  wire wr_cnt_lo = do_write && wr_b0 && aw_addr == TCC_OFS_CNT_LO;
  wire wr_cnt_hi = do_write && wr_b0 && aw_addr == TCC_OFS_CNT_HI;
  wire wr_cap_lo = do_write && wr_b0 && aw_addr == TCC_OFS_CAP_LO;
  wire wr_cap_hi = do_write && wr_b0 && aw_addr == TCC_OFS_CAP_HI;
  wire wr_flags = do_write && wr_b0 && aw_addr == TCC_OFS_FLAGS;
  wire wr_known = aw_addr <= TCC_OFS_STATUS && aw_addr[1:0] == 2'b00;

  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_cnt_lo = rd_take && s_axi_araddr == TCC_OFS_CNT_LO;
  wire rd_cap_lo = rd_take && s_axi_araddr == TCC_OFS_CAP_LO;
  wire rd_known = s_axi_araddr <= TCC_OFS_STATUS && s_axi_araddr[1:0] == 2'b00;

  wire [3:0] waveform_mode_field = {timer_control_b[TCC_B_WGM_HI +: 2],
                                    timer_control_a[TCC_A_WGM_LO +: 2]};
  wire [2:0] tick_source_select = timer_control_b[TCC_B_CS +: 3];
  wire noise_filter_enable = timer_control_b[TCC_B_FILT];
  wire edge_rising = timer_control_b[TCC_B_EDGE];
  wire comparator_capture_select = comparator_ctrl_status[TCC_CMP_SEL];

  // Modes 8, 10, 12 and 14 take the top value from the capture register.
  wire cap_is_top = waveform_mode_field == 4'h8 || waveform_mode_field == 4'hA ||
                    waveform_mode_field == 4'hC || waveform_mode_field == 4'hE;
  // Modes 9, 11 and 15 would take top from compare A, which is not here;
  // they run to the maximum value instead.
  wire dual_slope = waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                                                4'hA, 4'hB};
  wire clear_on_top = waveform_mode_field inside {4'h4, 4'h5, 4'h6, 4'h7,
                                                  4'hC, 4'hE, 4'hF};
  logic [15:0] top_value;
  always_comb begin
    case (waveform_mode_field[1:0])
      2'h1: top_value = TCC_TOP_8;
      2'h2: top_value = TCC_TOP_9;
      2'h3: top_value = TCC_TOP_10;
      default: top_value = TCC_MAX;
    endcase
    if (cap_is_top) begin
      top_value = capture_value;
    end else if (waveform_mode_field[3] || waveform_mode_field == 4'h4) begin
      top_value = TCC_MAX;
    end
  end

  // Prescaler and external tick source.
  logic [9:0] prescale;
  logic [2:0] ext_sync;
  logic ext_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 10'h000;
      ext_sync <= 3'h0;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_sync <= sync3(ext_sync, external_count_pin);
      if (ext_sync[2] == ext_sync[1]) begin
        ext_prev <= ext_sync[2];
      end
    end
  end
  wire ext_stable = ext_sync[2] == ext_sync[1];
  wire ext_rise = ext_stable && ext_sync[2] && !ext_prev;
  wire ext_fall = ext_stable && !ext_sync[2] && ext_prev;
  logic timer_tick;
  always_comb begin
    case (tcc_cs_t'(tick_source_select))
      TCC_CS_STOP: timer_tick = 1'b0;
      TCC_CS_DIV1: timer_tick = 1'b1;
      TCC_CS_DIV8: timer_tick = prescale[2:0] == 3'h7;
      TCC_CS_DIV64: timer_tick = prescale[5:0] == 6'h3F;
      TCC_CS_DIV256: timer_tick = prescale[7:0] == 8'hFF;
      TCC_CS_DIV1024: timer_tick = prescale == 10'h3FF;
      TCC_CS_EXT_FALL: timer_tick = ext_fall;
      TCC_CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  // Counter sequencing.
  wire at_top = timer_count == top_value;
  wire at_bottom = timer_count == TCC_BOTTOM;
  logic [15:0] next_count;
  logic next_down;
  logic ovf_event;
  always_comb begin
    next_count = timer_count;
    next_down = count_down;
    ovf_event = 1'b0;
    if (timer_tick) begin
      if (dual_slope) begin
        if (count_down && at_bottom) begin
          next_down = 1'b0;
          next_count = timer_count + 16'h0001;
          ovf_event = 1'b1;
        end else if (!count_down && at_top) begin
          next_down = 1'b1;
          next_count = timer_count - 16'h0001;
        end else begin
          next_count = count_down ? timer_count - 16'h0001 : timer_count + 16'h0001;
        end
      end else begin
        next_down = 1'b0;
        if (at_top && clear_on_top) begin
          next_count = TCC_BOTTOM;
          ovf_event = waveform_mode_field != 4'h4 && waveform_mode_field != 4'hC;
        end else begin
          next_count = timer_count + 16'h0001;
          ovf_event = timer_count == TCC_MAX;
        end
      end
    end
  end

  // Capture input: sync, filter, edge detection.
  wire cap_src = comparator_capture_select ? comparator_output : capture_pin;
  logic [2:0] cap_sync;
  logic cap_clean;
  logic [TCC_FILT_LEN-2:0] filt_hist;
  logic cap_filtered;
  logic cap_prev;
  wire cap_stable = cap_sync[2] == cap_sync[1];
  // The newest clean sample and the three before it must all agree.
  wire filt_agree = &{filt_hist, cap_clean} || ~|{filt_hist, cap_clean};
  wire cap_level = noise_filter_enable ? cap_filtered : cap_clean;
  wire cap_edge = edge_rising ? (cap_level && !cap_prev) : (!cap_level && cap_prev);
  wire cap_event = cap_edge && !cap_is_top;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_sync <= 3'h0;
      cap_clean <= 1'b0;
      filt_hist <= '0;
      cap_filtered <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cap_sync <= sync3(cap_sync, cap_src);
      if (cap_stable) begin
        cap_clean <= cap_sync[2];
      end
      // The filter runs on every system clock, whatever the tick source.
      filt_hist <= {filt_hist[TCC_FILT_LEN-3:0], cap_clean};
      if (filt_agree) begin
        cap_filtered <= cap_clean;
      end
      cap_prev <= cap_level;
    end
  end

  // Counter, capture register and shared latch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= TCC_BOTTOM;
      count_down <= 1'b0;
      capture_value <= TCC_BOTTOM;
      high_latch <= 8'h00;
    end else begin
      if (wr_cnt_lo) begin
        timer_count <= {high_latch, w_data[7:0]};
      end else begin
        timer_count <= next_count;
        count_down <= next_down;
      end
      if (cap_event) begin
        capture_value <= timer_count;
      end else if (wr_cap_lo && cap_is_top) begin
        capture_value <= {high_latch, w_data[7:0]};
      end
      if (wr_cnt_hi || wr_cap_hi) begin
        high_latch <= w_data[7:0];
      end else if (rd_cnt_lo) begin
        high_latch <= timer_count[15:8];
      end else if (rd_cap_lo) begin
        high_latch <= capture_value[15:8];
      end
    end
  end

  // Flags: a hardware set wins over a clear in the same cycle.
  wire ovf_clr = ovf_irq_ack || (wr_flags && w_data[TCC_FLG_OVF]);
  wire cap_clr = cap_irq_ack || (wr_flags && w_data[TCC_FLG_CAP]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
      ovf_irq <= 1'b0;
      cap_irq <= 1'b0;
      top_ind <= 1'b0;
      bottom_ind <= 1'b0;
    end else begin
      overflow_flag <= ovf_event || (overflow_flag && !ovf_clr);
      capture_flag <= cap_event || (capture_flag && !cap_clr);
      ovf_irq <= overflow_irq_enable && (ovf_event || (overflow_flag && !ovf_clr));
      cap_irq <= capture_irq_enable && (cap_event || (capture_flag && !cap_clr));
      top_ind <= next_count == top_value;
      bottom_ind <= next_count == TCC_BOTTOM;
    end
  end

  // Bus slave and control registers. Ready outputs are registered from the
  // next state of the channel they guard, so they still drop with a handshake.
  wire next_aw_held = !do_write && (aw_held || aw_take);
  wire next_w_held = !do_write && (w_held || w_take);
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  wire next_rvalid = rd_take || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCC_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      timer_control_a <= TCC_CTRL_RST;
      timer_control_b <= TCC_CTRL_RST;
      comparator_ctrl_status <= TCC_CTRL_RST;
      capture_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
        if (wr_b0 && aw_addr == TCC_OFS_CTRL_A) begin
          timer_control_a <= w_data[7:0];
        end
        if (wr_b0 && aw_addr == TCC_OFS_CTRL_B) begin
          timer_control_b <= w_data[7:0];
        end
        if (wr_b0 && aw_addr == TCC_OFS_CMP_CS) begin
          comparator_ctrl_status <= w_data[7:0];
        end
        if (wr_b0 && aw_addr == TCC_OFS_IRQ_EN) begin
          overflow_irq_enable <= w_data[TCC_FLG_OVF];
          capture_irq_enable <= w_data[TCC_FLG_CAP];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      TCC_OFS_CTRL_A: rd_byte = timer_control_a;
      TCC_OFS_CTRL_B: rd_byte = timer_control_b;
      TCC_OFS_CNT_LO: rd_byte = timer_count[7:0];
      TCC_OFS_CNT_HI: rd_byte = high_latch;
      TCC_OFS_CAP_LO: rd_byte = capture_value[7:0];
      TCC_OFS_CAP_HI: rd_byte = high_latch;
      TCC_OFS_FLAGS: rd_byte = 8'(overflow_flag) | (8'(capture_flag) << TCC_FLG_CAP);
      TCC_OFS_IRQ_EN: rd_byte = 8'(overflow_irq_enable) |
                                (8'(capture_irq_enable) << TCC_FLG_CAP);
      TCC_OFS_CMP_CS: rd_byte = comparator_ctrl_status;
      TCC_OFS_STATUS: rd_byte = {5'h00, timer_tick || tick_source_select != 3'h0,
                                 at_bottom, at_top};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TCC_RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !next_rvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_known ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== dv/tcc_timer_properties.sv ====
/*
  Checker for tcc_timer: bus handshakes, byte-wide read data and interrupt request clearing by ack.
  Assumes it sees only the top ports and is bound to every tcc_timer.
*/
module tcc_timer_properties (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupts and indications.
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  input wire logic ovf_irq,
  input wire logic cap_irq,
  input wire logic bottom_ind
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RD_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_BOT_RESET: assert property ($rose(aresetn) |=> bottom_ind)
    else $error("no bottom after reset");
  AST_CAP_ACK: assert property (cap_irq_ack |-> ##2 !cap_irq)
    else $error("capture request not cleared by ack");
  AST_OVF_ACK: assert property (ovf_irq_ack |-> ##2 !ovf_irq)
    else $error("overflow request not cleared by ack");

  COV_CAP: cover property ($rose(cap_irq));
  COV_OVF: cover property ($rose(ovf_irq));
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind tcc_timer tcc_timer_properties u_tcc_timer_properties (.*);

// ==== dv/tcc_pins.sv ====
/*
  Model of the logic beyond the timer pins: capture pin and comparator output.
  Assumes the bench calls drive() from its main process, just after an edge.
*/
module tcc_pins (
  // Clock.
  input wire logic aclk,
  // Pins towards the timer.
  output logic capture_pin,
  output logic comparator_output,
  output logic external_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The count pin stays quiet: only internal tick sources are exercised.
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    external_count_pin = 1'b0;
  end
  task automatic drive(input logic cap, input logic cmp, input int hold);
    @(posedge aclk);
    capture_pin <= cap;
    comparator_output <= cmp;
    repeat (hold) @(posedge aclk);
  endtask
endmodule

// ==== dv/tb_tcc_timer.sv ====
/*
  Self-checking bench for tcc_timer over AXI4-Lite, with pin stimulus model.
  Assumes the checker is bound by its own file and one 125 MHz clock.
*/
module tb_tcc_timer
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic ovf_irq_ack = 1'b0, cap_irq_ack = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, keep;
  logic ovf_irq, cap_irq, top_ind, bottom_ind;
  logic capture_pin, comparator_output, external_count_pin;
  int err_total = 0, compares = 0;
  int d0, d1, n;

  always #4 aclk = ~aclk;
  tcc_timer u_tcc_timer (.*);
  tcc_pins u_tcc_pins (.*);

  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) begin
      err_total++;
      report_and_stop;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      err_total++;
      report_and_stop;
    end
  endtask
  // A capture that never comes ends the run as a mismatch.
  task automatic wait_cap(output int c);
    for (c = 0; c < 40; c++) begin
      @(posedge aclk);
      if (cap_irq === 1'b1) break;
    end
    if (c == 40) begin
      err_total++;
      report_and_stop;
    end
  endtask
  task automatic wait_ovf;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (ovf_irq === 1'b1) break;
    end
    if (i == 100) begin
      err_total++;
      report_and_stop;
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(TCC_OFS_STATUS); chk(rd, 32'h2);
    chk({31'h0, bottom_ind}, 32'h1);
    chk({31'h0, top_ind}, 32'h0);
    wr(TCC_OFS_IRQ_EN, 8'h21);
    wr(TCC_OFS_CNT_HI, 8'h12); wr(TCC_OFS_CNT_LO, 8'h34);
    rdr(TCC_OFS_CNT_LO); chk(rd, 32'h34);
    rdr(TCC_OFS_CNT_HI); chk(rd, 32'h12);
    wr(TCC_OFS_CNT_HI, 8'h77); rdr(TCC_OFS_CNT_HI); chk(rd, 32'h77);
    rdr(TCC_OFS_CNT_LO); rdr(TCC_OFS_CNT_HI); chk(rd, 32'h12);
    s_axi_wstrb <= 4'hE;
    wr(TCC_OFS_CNT_HI, 8'hAA);
    chk_resp(rs, TCC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdr(TCC_OFS_CNT_HI);
    chk(rd, 32'h12);
    wr(8'h40, 8'h55); chk_resp(rs, TCC_RESP_SLVERR);
    rdr(8'h40); chk_resp(rs, TCC_RESP_SLVERR); chk(rd, 32'h0);
    // Counter held still so the captured value is exact.
    wr(TCC_OFS_CNT_HI, 8'h55); wr(TCC_OFS_CNT_LO, 8'h00); wr(TCC_OFS_CTRL_B, 8'h40);
    u_tcc_pins.drive(1'b1, 1'b0, 0); wait_cap(d0);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h20);
    rdr(TCC_OFS_CAP_LO); chk(rd, 32'h0);
    rdr(TCC_OFS_CAP_HI); chk(rd, 32'h55);
    @(posedge aclk); cap_irq_ack <= 1'b1;
    @(posedge aclk); cap_irq_ack <= 1'b0;
    repeat (2) @(posedge aclk); chk({31'h0, cap_irq}, 32'h0);
    u_tcc_pins.drive(1'b0, 1'b0, 0);
    repeat (40) @(posedge aclk);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    wr(TCC_OFS_CTRL_B, 8'hC0);
    u_tcc_pins.drive(1'b1, 1'b0, 0); wait_cap(d1);
    chk(32'(d1 - d0), 32'h4);
    wr(TCC_OFS_FLAGS, 8'h20); rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    u_tcc_pins.drive(1'b0, 1'b0, 0);
    repeat (40) @(posedge aclk);
    u_tcc_pins.drive(1'b1, 1'b0, 1); u_tcc_pins.drive(1'b0, 1'b0, 0);
    repeat (40) @(posedge aclk);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    wr(TCC_OFS_CTRL_B, 8'h00);
    u_tcc_pins.drive(1'b1, 1'b0, 0);
    repeat (40) @(posedge aclk);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    u_tcc_pins.drive(1'b0, 1'b0, 0); wait_cap(n);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h20);
    wr(TCC_OFS_CMP_CS, 8'h04); wr(TCC_OFS_FLAGS, 8'h20);
    wr(TCC_OFS_CNT_HI, 8'h66); wr(TCC_OFS_CNT_LO, 8'h00);
    u_tcc_pins.drive(1'b1, 1'b0, 0); u_tcc_pins.drive(1'b0, 1'b0, 0);
    repeat (40) @(posedge aclk);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    u_tcc_pins.drive(1'b0, 1'b1, 20); u_tcc_pins.drive(1'b0, 1'b0, 0); wait_cap(n);
    rdr(TCC_OFS_CAP_LO); rdr(TCC_OFS_CAP_HI); chk(rd, 32'h66);
    wr(TCC_OFS_FLAGS, 8'h21);
    wr(TCC_OFS_CNT_HI, 8'hFF); wr(TCC_OFS_CNT_LO, 8'hF0); wr(TCC_OFS_CTRL_B, 8'h01);
    wait_ovf;
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h1);
    @(posedge aclk); ovf_irq_ack <= 1'b1;
    @(posedge aclk); ovf_irq_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, ovf_irq}, 32'h0);
    wr(TCC_OFS_CNT_HI, 8'h80); wr(TCC_OFS_CNT_LO, 8'h00); wr(TCC_OFS_CTRL_B, 8'h00);
    rdr(TCC_OFS_CNT_LO); keep = rd;
    rdr(TCC_OFS_CNT_HI); chk(rd, 32'h80);
    rdr(TCC_OFS_CNT_LO); chk(rd, keep);
    // Eight-bit single slope: the count wraps at 0xFF instead of going on.
    wr(TCC_OFS_CNT_HI, 8'h00);
    wr(TCC_OFS_CNT_LO, 8'hF0);
    wr(TCC_OFS_CTRL_A, 8'h01);
    wr(TCC_OFS_CTRL_B, 8'h09);
    wait_ovf;
    wr(TCC_OFS_CTRL_B, 8'h00);
    wr(TCC_OFS_CTRL_A, 8'h00);
    rdr(TCC_OFS_CNT_LO);
    rdr(TCC_OFS_CNT_HI);
    chk(rd, 32'h0);
    wr(TCC_OFS_CNT_HI, 8'hFF);
    wr(TCC_OFS_CNT_LO, 8'hFF);
    rdr(TCC_OFS_STATUS);
    chk(rd, 32'h1);
    chk({31'h0, top_ind}, 32'h1);
    chk({31'h0, bottom_ind}, 32'h0);
    wr(TCC_OFS_CTRL_B, 8'h18); wr(TCC_OFS_FLAGS, 8'h21);
    wr(TCC_OFS_CAP_HI, 8'h12); wr(TCC_OFS_CAP_LO, 8'h34);
    wr(TCC_OFS_CNT_LO, 8'h56);
    rdr(TCC_OFS_CAP_LO); chk(rd, 32'h34);
    rdr(TCC_OFS_CAP_HI); chk(rd, 32'h12);
    rdr(TCC_OFS_CNT_LO);
    chk(rd, 32'h56);
    rdr(TCC_OFS_CNT_HI);
    chk(rd, 32'h12);
    u_tcc_pins.drive(1'b0, 1'b1, 20); u_tcc_pins.drive(1'b0, 1'b0, 0);
    repeat (40) @(posedge aclk);
    rdr(TCC_OFS_FLAGS); chk(rd, 32'h0);
    wr(TCC_OFS_CTRL_B, 8'h00); wr(TCC_OFS_CAP_HI, 8'h99); wr(TCC_OFS_CAP_LO, 8'h99);
    rdr(TCC_OFS_CAP_LO); chk(rd, 32'h34);
    report_and_stop;
  end
endmodule
